// file: core/sbs_pkg.sv
// Package with widths, counts and mode types for the burst SRAM pin model
package sbs_pkg;
   localparam int SBS_DATA_W = 36;
   localparam int SBS_ADDR_W = 17;
   localparam int SBS_LANES = 4;
   localparam int SBS_LANE_W = 9;
   localparam int SBS_NIB_W = 4;
   localparam int SBS_BURST = 4;
   localparam int SBS_DEPTH = 1024;
   localparam int SBS_IDX_W = 10;
   localparam logic [1:0] SBS_BEAT_LAST = 2'h3;
   localparam logic [1:0] SBS_BEAT_FIRST = 2'h0;
   typedef enum logic [1:0] {SBS_CFG_X8, SBS_CFG_X9, SBS_CFG_X18, SBS_CFG_X36} sbs_cfg_t;
   typedef enum {SBS_RD_IDLE, SBS_RD_BURST} sbs_rd_state_t;
endpackage : sbs_pkg

// file: core/sbs_lane_merge.sv
// Merge of one write beat into a stored word under nibble or lane masks
module sbs_lane_merge
   import sbs_pkg::*;
(
   input wire sbs_cfg_t cfg,
   input wire logic [SBS_DATA_W-1:0] oldWord,
   input wire logic [SBS_DATA_W-1:0] newWord,
   input wire logic [1:0] nibble_write_mask_n,
   input wire logic [SBS_LANES-1:0] byte_lane_mask_n,
   output logic [SBS_DATA_W-1:0] mergedWord
);
   logic [SBS_DATA_W-1:0] keepBits;
   always_comb begin
      keepBits = '0;
      if (cfg == SBS_CFG_X8) begin
         keepBits[SBS_NIB_W-1:0] = {SBS_NIB_W{nibble_write_mask_n[0]}};
         keepBits[2*SBS_NIB_W-1:SBS_NIB_W] = {SBS_NIB_W{nibble_write_mask_n[1]}};
      end else begin
         for (int i = 0; i < SBS_LANES; i++) begin
            keepBits[i*SBS_LANE_W +: SBS_LANE_W] = {SBS_LANE_W{byte_lane_mask_n[i]}};
         end
      end
   end
   // Masked lane keeps the stored bits, so the beat's data for that lane is dropped
   assign mergedWord = (oldWord & keepBits) | (newWord & ~keepBits);
endmodule // sbs_lane_merge

// file: core/sbs_burst_sram.sv
// Split-port four-beat burst SRAM core, both strobe edges mapped onto sys_clk beats
// Notes on behaviour
// - Write data is sampled on both strobe edges during a valid write.
// - Low write select starts a write; high select blocks a start but not the beats of a running burst.
// - Eight-bit mode: two nibble masks gate bits 3..0 and 7..4.
// - Wider modes: four masks each gate one nine-bit lane.
// - Each mask qualifies its own beat; masked lane data is discarded.
// - One shared address bus, sampled at the start of reads and writes.
// - Four equal arrays; address width 19, 18 or 17 by configuration.
// - Address is ignored on edges whose port select is deasserted.
// - Read data is driven each beat, from either timing pair.
// - Read data outputs are released when the read port is idle.
// - Low read select starts a read; high select deselects the read port.
// - A deselected read port finishes its burst, then releases outputs.
// - Each read returns four sequential beats from the addressed location.
// - Accesses start on the positive strobe; single-clock mode times reads on it.
module sbs_burst_sram
   import sbs_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire sbs_cfg_t cfg,
   input wire logic singleClockMode,
   input wire logic read_port_select_n,
   input wire logic write_port_select_n,
   input wire logic [SBS_ADDR_W+1:0] addr,
   input wire logic [SBS_DATA_W-1:0] writeData,
   input wire logic [1:0] nibble_write_mask_n,
   input wire logic [SBS_LANES-1:0] byte_lane_mask_n,
   output logic [SBS_DATA_W-1:0] readData,
   output logic readDataOe,
   output logic readBeatStrobe,
   output logic readTimingSel
);
   // Sim-sized model: only the low index bits select a row; full address is decoded by width
   logic [SBS_DATA_W-1:0] memArray [SBS_DEPTH];
   sbs_rd_state_t rdState_r, rdState_nxt;
   logic [1:0] rdBeat_r, rdBeat_nxt;
   logic [1:0] wrBeat_r, wrBeat_nxt;
   logic wrActive_r, wrActive_nxt;
   logic [SBS_ADDR_W+1:0] rdAddr_r, rdAddr_nxt;
   logic [SBS_ADDR_W+1:0] wrAddr_r, wrAddr_nxt;
   logic [SBS_DATA_W-1:0] readData_r;
   logic readDataOe_r;
   logic readStartRow;
   logic writeStartBeat;
   logic writeBeatLive;
   logic [SBS_ADDR_W+1:0] wrBase;
   logic [SBS_IDX_W-1:0] wrIdx;
   logic [SBS_IDX_W-1:0] rdIdx;
   logic [SBS_DATA_W-1:0] widthMask;
   logic [SBS_DATA_W-1:0] mergedWord;
   logic [SBS_DATA_W-1:0] rdWord;

   // Address width by configuration, four arrays deep per location
   function automatic logic [SBS_ADDR_W+1:0] addrTrim(input sbs_cfg_t c, input logic [SBS_ADDR_W+1:0] a);
      logic [SBS_ADDR_W+1:0] m;
      m = '1;
      case (c)
         SBS_CFG_X8, SBS_CFG_X9: m = '1;
         SBS_CFG_X18: m = {1'b0, {(SBS_ADDR_W+1){1'b1}}};
         SBS_CFG_X36: m = {2'b00, {SBS_ADDR_W{1'b1}}};
         default: m = '1;
      endcase
      return a & m;
   endfunction

   // Each beat of a burst is one row: location times four plus beat
   function automatic logic [SBS_IDX_W-1:0] rowIdx(input logic [SBS_ADDR_W+1:0] a, input logic [1:0] b);
      return {a[SBS_IDX_W-3:0], b};
   endfunction

   always_comb begin
      widthMask = '0;
      case (cfg)
         SBS_CFG_X8: widthMask[7:0] = '1;
         SBS_CFG_X9: widthMask[8:0] = '1;
         SBS_CFG_X18: widthMask[17:0] = '1;
         SBS_CFG_X36: widthMask = '1;
         default: widthMask = '1;
      endcase
   end

   // Beats alternate: even beat is the positive strobe edge, odd the negative
   assign readStartRow = (rdState_r == SBS_RD_IDLE || rdBeat_r == SBS_BEAT_LAST) && !read_port_select_n;
   assign writeStartBeat = !wrActive_r && !write_port_select_n;
   assign writeBeatLive = writeStartBeat || wrActive_r;
   // Address taken only when the write starts; later beats ignore the pins
   assign wrBase = writeStartBeat ? addrTrim(cfg, addr) : wrAddr_r;
   assign wrIdx = rowIdx(wrBase, wrBeat_r);
   assign rdIdx = rowIdx(readStartRow ? addrTrim(cfg, addr) : rdAddr_r,
                         readStartRow ? SBS_BEAT_FIRST : rdBeat_r + 2'h1);
   assign rdWord = memArray[rdIdx];

   sbs_lane_merge u_merge (
      .cfg(cfg),
      .oldWord(memArray[wrIdx]),
      .newWord(writeData & widthMask),
      .nibble_write_mask_n(nibble_write_mask_n),
      .byte_lane_mask_n(byte_lane_mask_n),
      .mergedWord(mergedWord)
   );

   always_comb begin
      rdState_nxt = rdState_r;
      rdBeat_nxt = rdBeat_r;
      rdAddr_nxt = rdAddr_r;
      case (rdState_r)
         SBS_RD_IDLE: begin
            if (readStartRow) begin
               rdState_nxt = SBS_RD_BURST;
               rdBeat_nxt = SBS_BEAT_FIRST;
               rdAddr_nxt = addrTrim(cfg, addr);
            end
         end
         SBS_RD_BURST: begin
            if (rdBeat_r != SBS_BEAT_LAST) begin
               rdBeat_nxt = rdBeat_r + 2'h1;
            end else if (readStartRow) begin
               rdBeat_nxt = SBS_BEAT_FIRST;
               rdAddr_nxt = addrTrim(cfg, addr);
            end else begin
               rdState_nxt = SBS_RD_IDLE;
            end
         end
         default: rdState_nxt = SBS_RD_IDLE;
      endcase
   end

   always_comb begin
      wrActive_nxt = wrActive_r;
      wrBeat_nxt = wrBeat_r;
      wrAddr_nxt = wrAddr_r;
      if (writeBeatLive) begin
         wrAddr_nxt = wrBase;
         if (wrBeat_r == SBS_BEAT_LAST) begin
            wrActive_nxt = 1'b0;
            wrBeat_nxt = SBS_BEAT_FIRST;
         end else begin
            wrActive_nxt = 1'b1;
            wrBeat_nxt = wrBeat_r + 2'h1;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdState_r <= SBS_RD_IDLE;
         rdBeat_r <= SBS_BEAT_FIRST;
         rdAddr_r <= '0;
         wrActive_r <= 1'b0;
         wrBeat_r <= SBS_BEAT_FIRST;
         wrAddr_r <= '0;
         readData_r <= '0;
         readDataOe_r <= 1'b0;
      end else begin
         rdState_r <= rdState_nxt;
         rdBeat_r <= rdBeat_nxt;
         rdAddr_r <= rdAddr_nxt;
         wrActive_r <= wrActive_nxt;
         wrBeat_r <= wrBeat_nxt;
         wrAddr_r <= wrAddr_nxt;
         // Output register: one beat latency; drivers off once the burst is done
         readDataOe_r <= (rdState_nxt == SBS_RD_BURST);
         readData_r <= (rdState_nxt == SBS_RD_BURST) ? (rdWord & widthMask) : '0;
      end
   end

   // Array holds no reset, as a real SRAM core
   always_ff @(posedge sys_clk) begin
      if (writeBeatLive) begin
         memArray[wrIdx] <= mergedWord;
      end
   end

   assign readData = readData_r;
   assign readDataOe = readDataOe_r;
   assign readBeatStrobe = readDataOe_r;
   assign readTimingSel = singleClockMode;

   beat_count_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      $rose(readDataOe) |-> readDataOe [*4])
      else $error("Read burst shorter than four beats");
   oe_release_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (rdState_r == SBS_RD_IDLE && read_port_select_n) |=> !readDataOe)
      else $error("Outputs driven with read port idle");
   read_start_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (rdState_r == SBS_RD_IDLE && !read_port_select_n) |=> readDataOe && rdBeat_r == SBS_BEAT_FIRST)
      else $error("Read did not start on select");
   write_len_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (!wrActive_r && !write_port_select_n) |=> wrActive_r [*3] ##1 !wrActive_r)
      else $error("Write burst not four beats");
   write_ignore_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (!wrActive_r && write_port_select_n) |=> !wrActive_r && wrBeat_r == SBS_BEAT_FIRST)
      else $error("Write started while deselected");
   wr_addr_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      wrActive_r |=> wrAddr_r == $past(wrAddr_r))
      else $error("Write address moved mid burst");
   rd_addr_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (rdState_r == SBS_RD_BURST && rdBeat_r != SBS_BEAT_LAST) |=> rdAddr_r == $past(rdAddr_r))
      else $error("Read address moved mid burst");
   // A select held low during beats 0..2 must neither restart nor stretch the burst
   rd_ignore_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (rdState_r == SBS_RD_BURST && rdBeat_r != SBS_BEAT_LAST && !read_port_select_n)
      |=> readDataOe && rdBeat_r == $past(rdBeat_r) + 2'h1)
      else $error("Read select honoured mid burst");
   rd_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !readDataOe |-> readData == '0)
      else $error("Read data shown while released");
   // Only live writes count: a stale address from an earlier mode is never used
   addr_width_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (cfg == SBS_CFG_X36 && writeBeatLive) |-> wrBase[SBS_ADDR_W+1:SBS_ADDR_W] == 2'b00)
      else $error("Address above width in wide mode");
   lane_keep_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (writeBeatLive && cfg != SBS_CFG_X8 && byte_lane_mask_n[0])
      |-> mergedWord[SBS_LANE_W-1:0] == memArray[wrIdx][SBS_LANE_W-1:0])
      else $error("Masked lane was written");
   nib_keep_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (writeBeatLive && cfg == SBS_CFG_X8 && nibble_write_mask_n[1])
      |-> mergedWord[7:4] == memArray[wrIdx][7:4])
      else $error("Masked nibble was written");
endmodule // sbs_burst_sram

// file: verif/sbs_ctrl_model.sv
// Memory controller model driving selects, the shared address, write beats and masks
module sbs_ctrl_model
   import sbs_pkg::*;
(
   input wire logic sys_clk,
   output logic read_port_select_n,
   output logic write_port_select_n,
   output logic [SBS_ADDR_W+1:0] addr,
   output logic [SBS_DATA_W-1:0] writeData,
   output logic [1:0] nibble_write_mask_n,
   output logic [SBS_LANES-1:0] byte_lane_mask_n
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      read_port_select_n = 1'b1;
      write_port_select_n = 1'b1;
      addr = '0;
      writeData = '0;
      nibble_write_mask_n = '1;
      byte_lane_mask_n = '1;
   end

   // Idle address and data lines flip so a stale value is never mistaken for a sampled one
   task automatic writeBurst(input logic [SBS_ADDR_W+1:0] a, input logic [3:0][SBS_DATA_W-1:0] d,
      input logic [3:0][5:0] m);
      for (int b = 0; b < SBS_BURST; b++) begin
         @(negedge sys_clk);
         write_port_select_n = (b != 0);
         addr = (b == 0) ? a : ~a;
         writeData = d[b];
         {nibble_write_mask_n, byte_lane_mask_n} = m[b];
      end
      @(negedge sys_clk);
      write_port_select_n = 1'b1;
      writeData = ~writeData;
   endtask

   task automatic startRead(input logic [SBS_ADDR_W+1:0] a, input logic hold);
      @(negedge sys_clk);
      read_port_select_n = 1'b0;
      addr = a;
      @(negedge sys_clk);
      // A held select mid-burst and the flipped address must both be ignored
      read_port_select_n = !hold;
      addr = ~a;
   endtask

   // Called off the sampling edge, before the burst reaches its last beat
   task automatic releaseRead();
      read_port_select_n = 1'b1;
   endtask
endmodule // sbs_ctrl_model

// file: verif/split_port_burst4_sram_pins_test.sv
// Self-checking bench for the burst SRAM pin core
module split_port_burst4_sram_pins_test
   import sbs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk, rst_n, singleClockMode, rdSel, wrSel, readDataOe, readBeatStrobe, readTimingSel;
   sbs_cfg_t cfg;
   logic [SBS_ADDR_W+1:0] addr, a;
   logic [SBS_DATA_W-1:0] writeData, readData;
   logic [1:0] nibMask;
   logic [SBS_LANES-1:0] laneMask;
   logic [3:0][SBS_DATA_W-1:0] d;
   logic [3:0][5:0] m;
   logic [SBS_DATA_W-1:0] expMem [0:SBS_DEPTH-1];
   int seed = 69984;
   int fail_count = 0;
   int cmp_count = 0;

   sbs_ctrl_model ctrl (.sys_clk(sys_clk), .read_port_select_n(rdSel), .write_port_select_n(wrSel),
      .addr(addr), .writeData(writeData), .nibble_write_mask_n(nibMask), .byte_lane_mask_n(laneMask));
   sbs_burst_sram DUT (.sys_clk(sys_clk), .rst_n(rst_n), .cfg(cfg), .singleClockMode(singleClockMode),
      .read_port_select_n(rdSel), .write_port_select_n(wrSel), .addr(addr), .writeData(writeData),
      .nibble_write_mask_n(nibMask), .byte_lane_mask_n(laneMask), .readData(readData),
      .readDataOe(readDataOe), .readBeatStrobe(readBeatStrobe), .readTimingSel(readTimingSel));

   function automatic logic [SBS_DATA_W-1:0] mergeExp(sbs_cfg_t c, logic [SBS_DATA_W-1:0] o,
      logic [SBS_DATA_W-1:0] n, logic [5:0] k);
      logic [SBS_DATA_W-1:0] keep;
      if (c == SBS_CFG_X8) keep = {28'h0, {4{k[5]}}, {4{k[4]}}};
      else keep = {{9{k[3]}}, {9{k[2]}}, {9{k[1]}}, {9{k[0]}}};
      return (o & keep) | (n & ~keep);
   endfunction

   // Upper bits beyond the configured width carry no meaning and are left out of the per-beat data comparisons
   function automatic logic [SBS_DATA_W-1:0] widthMask(sbs_cfg_t c);
      case (c)
         SBS_CFG_X8: return 36'hff;
         SBS_CFG_X9: return 36'h1ff;
         SBS_CFG_X18: return 36'h3ffff;
         default: return 36'hf_ffff_ffff;
      endcase
   endfunction

   task automatic check(input string name, input logic [SBS_DATA_W-1:0] seen, input logic [SBS_DATA_W-1:0] expd);
      cmp_count++;
      if (seen !== expd) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", name, expd, seen);
      end
   endtask

   task automatic conclude();
      if (fail_count == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic writeExp();
      ctrl.writeBurst(a, d, m);
      for (int b = 0; b < SBS_BURST; b++) begin
         expMem[{a[7:0], 2'(b)}] = mergeExp(cfg, expMem[{a[7:0], 2'(b)}], d[b], m[b]);
      end
   endtask

   // Beat 0 already stands at the falling edge on which a read without hold drops its request
   task automatic readCheck(input logic hold);
      logic [SBS_DATA_W-1:0] wm;
      wm = widthMask(cfg);
      ctrl.startRead(a, hold);
      for (int b = 0; b < SBS_BURST; b++) begin
         check("readDataOe", readDataOe, 1'b1);
         check("readBeatStrobe", readBeatStrobe, 1'b1);
         check("readData", readData & wm, expMem[{a[7:0], 2'(b)}] & wm);
         if (b == 2) begin
            ctrl.releaseRead();
         end
         @(negedge sys_clk);
      end
      check("readTimingSel", readTimingSel, singleClockMode);
      check("idleOe", readDataOe, 1'b0);
      check("idleData", readData, '0);
   endtask

   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   initial begin
      #100000;
      fail_count++;
      conclude();
   end

   initial begin
      cfg = SBS_CFG_X36;
      singleClockMode = 1'b0;
      rst_n = 1'b0;
      repeat (8) @(negedge sys_clk);
      check("resetOe", readDataOe, 1'b0);
      rst_n = 1'b1;
      for (int c = 0; c < 4; c++) begin
         cfg = sbs_cfg_t'(c);
         for (int i = 0; i < 6; i++) begin
            a = (SBS_ADDR_W+2)'($random(seed));
            singleClockMode = 1'($random(seed));
            for (int b = 0; b < SBS_BURST; b++) begin
               d[b] = SBS_DATA_W'({$random(seed), $random(seed)});
               m[b] = 6'h0;
            end
            writeExp();
            // First pass masks every lane, so the whole burst must be discarded
            for (int b = 0; b < SBS_BURST; b++) begin
               d[b] = SBS_DATA_W'({$random(seed), $random(seed)});
               m[b] = (i == 0) ? 6'h3f : 6'($random(seed));
            end
            writeExp();
            readCheck(i[0]);
         end
      end
      conclude();
   end
endmodule // split_port_burst4_sram_pins_test
